// >>> phpc_map.svh
// register map, field positions, reset values and timing of the highway port
// included by the package user files; definitions only
`ifndef PHPC_MAP_SVH
`define PHPC_MAP_SVH
`define PHPC_IDX_MODE 6'h01
`define PHPC_IDX_TXLO 6'h02
`define PHPC_IDX_TXHI 6'h03
`define PHPC_IDX_RXLO 6'h04
`define PHPC_IDX_RXHI 6'h05
`define PHPC_IDX_PID 6'h06
`define PHPC_IDX_LOOP 6'h08
`define PHPC_MODE_PID2 7
`define PHPC_MODE_WB 6
`define PHPC_MODE_EN 5
`define PHPC_MODE_FMT_HI 4
`define PHPC_MODE_FMT_LO 3
`define PHPC_MODE_SIZE 2
`define PHPC_MODE_DBL 1
`define PHPC_MODE_TRI 0
`define PHPC_FMT_ALAW 2'h0
`define PHPC_FMT_MULAW 2'h1
`define PHPC_FMT_LINEAR 2'h3
`define PHPC_RST_MODE 7'h00
`define PHPC_RST_START 10'h000
`define PHPC_RST_LOOP 3'h0
// part id value is arbitrary, chosen for this block only
`define PHPC_PART_ID 3'h2
`define PHPC_BITS_NARROW 5'h08
`define PHPC_BITS_WIDE 5'h10
`endif

// >>> phpc_pkg.sv
// types shared by the highway port files
// assumes phpc_map.svh holds the numbers
package phpc_pkg;
	typedef struct packed {
		logic wideband_select;
		logic highway_transfer_enable;
		logic [1:0] sample_format_select;
		logic transfer_size_select;
		logic double_clock_per_bit;
		logic release_on_fall;
	} phpc_mode_s;
	typedef struct packed {
		logic full_analog_loopback;
		logic digital_loopback;
		logic partial_analog_loopback;
	} phpc_loop_s;
	typedef enum logic [1:0] {PHPC_IDLE, PHPC_BUSY} phpc_dir_e;
endpackage

// >>> phpc_sync.sv
// two flip-flop synchroniser for a group of pin levels
// assumes inputs are asynchronous to clk_sys
`timescale 1ns/1ps
module phpc_sync #(parameter int W = 3) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_r;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			meta_r <= '0;
			dout <= '0;
		end else begin
			meta_r <= din;
			dout <= meta_r;
		end
	end
endmodule

// >>> phpc_buf.sv
// two-entry buffer with valid and ready on both sides
// assumes one clock; in_ready is a flop so the source sees a clean stall
`timescale 1ns/1ps
module phpc_buf #(parameter int W = 16, parameter int D = 2) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	logic [W-1:0] mem_r [D];
	logic [$clog2(D)-1:0] wp_r, rp_r;
	logic [$clog2(D):0] cnt_r;
	logic push, pop;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_valid = cnt_r != '0;
	assign out_data = mem_r[rp_r];
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			in_ready <= 1'b1;
		end else begin
			if (push)
				wp_r <= wp_r + 1'b1;
			if (pop)
				rp_r <= rp_r + 1'b1;
			cnt_r <= cnt_r + {{$clog2(D){1'b0}}, push} - {{$clog2(D){1'b0}}, pop};
			in_ready <= (cnt_r + {{$clog2(D){1'b0}}, push} - {{$clog2(D){1'b0}}, pop})
				< ($clog2(D)+1)'(D);
		end
	end
	always_ff @(posedge clk_sys) begin
		if (push)
			mem_r[wp_r] <= in_data;
	end
endmodule

// >>> phpc_top.sv
// highway port control: apb registers, frame timing, serial tx and rx
// assumes the highway master drives pclk and frame sync; apb on clk_sys
// Contract
// [RULE_01] wideband 16 kHz only with wideband flag, linear format and 16-bit size
// [RULE_02] no transmit or receive transfer while transfer enable is zero
// [RULE_03] format field: 00 a-law, 01 mu-law, 11 linear, 10 reserved
// [RULE_04] transfer size bit selects 8 or 16 bits per sample
// [RULE_05] clock format bit gives one or two bit clocks per data bit
// [RULE_06] release tx after bit 0 on rising or falling edge per edge bit
// [RULE_07] tx starts after a 10-bit count of bit clocks after frame sync
// [RULE_08] rx starts after its own 10-bit count of bit clocks after frame sync
// [RULE_09] read-only part id in id register top bits, mirrored in mode register
// [RULE_10] full analog loopback follows its control bit
// [RULE_11] digital loopback follows its control bit
// [RULE_12] partial analog loopback follows its control bit
// [RULE_13] master supplies continuous bit clock and one frame sync per frame
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "phpc_map.svh"
module phpc_top (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pcm_clk,
	input wire logic highway_frame_sync,
	input wire logic pcm_rx_data,
	output logic pcm_tx_data,
	output logic pcm_tx_oe,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [15:0] tx_word,
	output logic rx_valid,
	output logic [15:0] rx_word,
	output logic wideband_active,
	output logic [1:0] sample_format,
	output phpc_pkg::phpc_loop_s loop_mode
);
	phpc_pkg::phpc_mode_s mode_r;
	phpc_pkg::phpc_loop_s loop_r;
	phpc_pkg::phpc_dir_e tx_st_r, rx_st_r;
	logic [9:0] tx_start_r, rx_start_r;
	logic [10:0] frame_cnt_r;
	logic [4:0] tx_left_r, rx_left_r;
	logic [15:0] tx_sh_r, rx_sh_r;
	logic [15:0] rx_sh_nxt;
	localparam logic [2:0] PART_ID = `PHPC_PART_ID;
	logic rx_take_r, clk_d_r, fs_d_r;
	logic clk_s, fs_s, drx_s;
	logic clk_rise, clk_fall, fs_rise, acc, wr, rd_setup;
	logic [5:0] idx;
	logic [4:0] nbits, total_m1;
	logic buf_valid, buf_pop, tx_go, rx_go, rx_bit;
	logic [15:0] buf_data;

	function automatic logic [7:0] reg_read(input logic [5:0] i);
		case (i)
			`PHPC_IDX_MODE: reg_read = {PART_ID[2], mode_r}; // RULE_09
			`PHPC_IDX_TXLO: reg_read = tx_start_r[7:0];
			`PHPC_IDX_TXHI: reg_read = {6'h00, tx_start_r[9:8]};
			`PHPC_IDX_RXLO: reg_read = rx_start_r[7:0];
			`PHPC_IDX_RXHI: reg_read = {6'h00, rx_start_r[9:8]};
			`PHPC_IDX_PID: reg_read = {`PHPC_PART_ID, 5'h00}; // RULE_09
			`PHPC_IDX_LOOP: reg_read = {5'h00, loop_r};
			default: reg_read = 8'h00;
		endcase
	endfunction

	function automatic logic mapped(input logic [5:0] i);
		mapped = (i >= `PHPC_IDX_MODE && i <= `PHPC_IDX_PID) || i == `PHPC_IDX_LOOP;
	endfunction

	phpc_sync #(.W(3)) u_sync (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.din({pcm_clk, highway_frame_sync, pcm_rx_data}),
		.dout({clk_s, fs_s, drx_s})
	);

	phpc_buf #(.W(16), .D(2)) u_buf (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.in_data(tx_word),
		.out_valid(buf_valid),
		.out_ready(buf_pop),
		.out_data(buf_data)
	);

	// apb: one access cycle, no wait states; byte address is four times the index
	assign idx = paddr[7:2];
	assign acc = psel && penable && pready;
	assign wr = acc && pwrite && mapped(idx);
	assign rd_setup = psel && !penable;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= rd_setup;
			pslverr <= rd_setup && (!mapped(idx) || paddr[1:0] != 2'h0);
			// a misaligned read returns zero, not the word it would alias
			if (rd_setup && !pwrite)
				prdata <= (paddr[1:0] == 2'h0) ? {24'h00_0000, reg_read(idx)} : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			mode_r <= `PHPC_RST_MODE;
			tx_start_r <= `PHPC_RST_START;
			rx_start_r <= `PHPC_RST_START;
			loop_r <= `PHPC_RST_LOOP;
		end else if (wr && paddr[1:0] == 2'h0) begin
			case (idx)
				`PHPC_IDX_MODE: mode_r <= pwdata[6:0];
				`PHPC_IDX_TXLO: tx_start_r[7:0] <= pwdata[7:0]; // RULE_07
				`PHPC_IDX_TXHI: tx_start_r[9:8] <= pwdata[1:0]; // RULE_07
				`PHPC_IDX_RXLO: rx_start_r[7:0] <= pwdata[7:0]; // RULE_08
				`PHPC_IDX_RXHI: rx_start_r[9:8] <= pwdata[1:0]; // RULE_08
				`PHPC_IDX_LOOP: loop_r <= pwdata[2:0];
				default: ;
			endcase
		end
	end

	// mode outputs for the filter and codec paths
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wideband_active <= 1'b0;
			sample_format <= `PHPC_FMT_ALAW;
			loop_mode <= `PHPC_RST_LOOP;
		end else begin
			wideband_active <= mode_r.wideband_select && mode_r.transfer_size_select
				&& mode_r.sample_format_select == `PHPC_FMT_LINEAR; // RULE_01
			sample_format <= mode_r.sample_format_select; // RULE_03
			loop_mode <= loop_r; // RULE_10 RULE_11 RULE_12
		end
	end

	// edges of the synchronised bit clock and frame sync
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			clk_d_r <= 1'b0;
			fs_d_r <= 1'b0;
		end else begin
			clk_d_r <= clk_s;
			fs_d_r <= fs_s;
		end
	end
	assign clk_rise = clk_s && !clk_d_r;
	assign clk_fall = !clk_s && clk_d_r;
	assign fs_rise = fs_s && !fs_d_r;

	// bit clocks since frame sync, first rise after sync counts as zero
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			frame_cnt_r <= 11'h7ff;
		else if (fs_rise)
			frame_cnt_r <= 11'h7ff;
		else if (clk_rise && frame_cnt_r != 11'h7fe)
			frame_cnt_r <= frame_cnt_r + 11'h001; // RULE_13
	end

	assign nbits = mode_r.transfer_size_select ? `PHPC_BITS_WIDE : `PHPC_BITS_NARROW; // RULE_04
	// a doubled clock stretches every bit over two bit clocks
	assign total_m1 = mode_r.double_clock_per_bit ? 5'((nbits << 1) - 5'h01)
		: 5'(nbits - 5'h01); // RULE_05
	assign tx_go = clk_rise && mode_r.highway_transfer_enable && !fs_rise
		&& frame_cnt_r + 11'h001 == {1'b0, tx_start_r}; // RULE_02 RULE_07
	assign rx_go = clk_rise && mode_r.highway_transfer_enable && !fs_rise
		&& frame_cnt_r + 11'h001 == {1'b0, rx_start_r}; // RULE_02 RULE_08
	assign buf_pop = tx_go && buf_valid;

	// transmit: an empty buffer sends zeros rather than stalling the highway
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			tx_st_r <= phpc_pkg::PHPC_IDLE;
			tx_left_r <= 5'h00;
			tx_sh_r <= 16'h0000;
			pcm_tx_data <= 1'b0;
			pcm_tx_oe <= 1'b0;
		end else if (tx_go) begin
			tx_st_r <= phpc_pkg::PHPC_BUSY;
			tx_left_r <= total_m1;
			tx_sh_r <= buf_valid ? buf_data : 16'h0000;
			pcm_tx_data <= mode_r.transfer_size_select ? buf_valid && buf_data[15]
				: buf_valid && buf_data[7];
			pcm_tx_oe <= 1'b1;
		end else if (tx_st_r == phpc_pkg::PHPC_BUSY) begin
			if (clk_rise) begin
				if (tx_left_r == 5'h00) begin
					tx_st_r <= phpc_pkg::PHPC_IDLE;
					pcm_tx_oe <= 1'b0; // RULE_06
				end else begin
					tx_left_r <= tx_left_r - 5'h01;
					if (!mode_r.double_clock_per_bit || !tx_left_r[0]) begin // RULE_05
						tx_sh_r <= tx_sh_r << 1;
						pcm_tx_data <= mode_r.transfer_size_select ? tx_sh_r[14]
							: tx_sh_r[6];
					end
				end
			end else if (clk_fall && tx_left_r == 5'h00 && mode_r.release_on_fall) begin
				tx_st_r <= phpc_pkg::PHPC_IDLE;
				pcm_tx_oe <= 1'b0; // RULE_06
			end
		end
	end

	// receive: sample on the first falling edge of each bit, mid-bit at one clock per bit; digital loopback takes tx bit
	assign rx_bit = loop_r.digital_loopback ? pcm_tx_data : drx_s; // RULE_11
	// in double clock mode the last fall takes no bit, so the word is the shifter as is
	assign rx_sh_nxt = rx_take_r ? {rx_sh_r[14:0], rx_bit} : rx_sh_r;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rx_st_r <= phpc_pkg::PHPC_IDLE;
			rx_left_r <= 5'h00;
			rx_sh_r <= 16'h0000;
			rx_take_r <= 1'b0;
			rx_valid <= 1'b0;
			rx_word <= 16'h0000;
		end else begin
			rx_valid <= 1'b0;
			if (rx_go) begin
				rx_st_r <= phpc_pkg::PHPC_BUSY;
				rx_left_r <= total_m1;
				rx_sh_r <= 16'h0000;
				rx_take_r <= 1'b1;
			end else if (rx_st_r == phpc_pkg::PHPC_BUSY) begin
				if (clk_rise && rx_left_r != 5'h00) begin
					rx_left_r <= rx_left_r - 5'h01;
					rx_take_r <= !mode_r.double_clock_per_bit || !rx_left_r[0];
				end else if (clk_fall) begin
					rx_sh_r <= rx_sh_nxt;
					rx_take_r <= 1'b0;
					if (rx_left_r == 5'h00) begin
						rx_st_r <= phpc_pkg::PHPC_IDLE;
						rx_valid <= 1'b1;
						rx_word <= mode_r.transfer_size_select ? rx_sh_nxt
							: {8'h00, rx_sh_nxt[7:0]}; // RULE_04
					end
				end
			end
		end
	end

	property p_wideband;
		@(posedge clk_sys) disable iff (!reset_n)
		wideband_active |-> $past(mode_r.sample_format_select) == `PHPC_FMT_LINEAR
			&& $past(mode_r.transfer_size_select) && $past(mode_r.wideband_select);
	endproperty
	a_wideband: assert property (p_wideband) else $error("wideband without linear 16-bit"); // RULE_01

	property p_no_tx_disabled;
		@(posedge clk_sys) disable iff (!reset_n)
		$rose(pcm_tx_oe) |-> $past(mode_r.highway_transfer_enable);
	endproperty
	a_no_tx_disabled: assert property (p_no_tx_disabled) else $error("tx while disabled"); // RULE_02

	property p_no_rx_disabled;
		@(posedge clk_sys) disable iff (!reset_n)
		$rose(rx_st_r == phpc_pkg::PHPC_BUSY) |-> $past(mode_r.highway_transfer_enable);
	endproperty
	a_no_rx_disabled: assert property (p_no_rx_disabled) else $error("rx while disabled"); // RULE_02

	property p_fmt_out;
		@(posedge clk_sys) disable iff (!reset_n)
		##1 sample_format == $past(mode_r.sample_format_select);
	endproperty
	a_fmt_out: assert property (p_fmt_out) else $error("format output stale"); // RULE_03

	property p_tx_len;
		@(posedge clk_sys) disable iff (!reset_n)
		tx_go |=> tx_left_r == (mode_r.transfer_size_select ? 5'd15 : 5'd7)
			+ (mode_r.double_clock_per_bit ? (mode_r.transfer_size_select ? 5'd16 : 5'd8)
			: 5'd0);
	endproperty
	a_tx_len: assert property (p_tx_len) else $error("wrong transfer length"); // RULE_04

	property p_release_fall;
		@(posedge clk_sys) disable iff (!reset_n)
		$fell(pcm_tx_oe) |-> ($past(clk_fall) && $past(mode_r.release_on_fall))
			|| $past(clk_rise);
	endproperty
	a_release_fall: assert property (p_release_fall) else $error("tx released off edge"); // RULE_06

	property p_tx_start;
		@(posedge clk_sys) disable iff (!reset_n)
		$rose(pcm_tx_oe) |-> $past(frame_cnt_r) + 11'h001 == {1'b0, $past(tx_start_r)};
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("tx start off count"); // RULE_07

	property p_rx_start;
		@(posedge clk_sys) disable iff (!reset_n)
		$rose(rx_st_r == phpc_pkg::PHPC_BUSY) |->
			$past(frame_cnt_r) + 11'h001 == {1'b0, $past(rx_start_r)};
	endproperty
	a_rx_start: assert property (p_rx_start) else $error("rx start off count"); // RULE_08

	property p_part_id;
		@(posedge clk_sys) disable iff (!reset_n)
		rd_setup && !pwrite && idx == `PHPC_IDX_PID && paddr[1:0] == 2'h0
			|=> prdata[7:5] == `PHPC_PART_ID && pready;
	endproperty
	a_part_id: assert property (p_part_id) else $error("part id readback wrong"); // RULE_09

	property p_loop;
		@(posedge clk_sys) disable iff (!reset_n)
		wr && idx == `PHPC_IDX_LOOP && paddr[1:0] == 2'h0
			|=> ##1 loop_mode == $past(pwdata[2:0], 2);
	endproperty
	a_loop: assert property (p_loop) else $error("loopback not applied"); // RULE_10 RULE_11 RULE_12

	c_tx: cover property (@(posedge clk_sys) disable iff (!reset_n) $fell(pcm_tx_oe));
	c_rx: cover property (@(posedge clk_sys) disable iff (!reset_n) rx_valid);
	c_wide: cover property (@(posedge clk_sys) disable iff (!reset_n) wideband_active);
endmodule

// >>> phpc_hwy_master.sv
// highway master model: bit clock, frame sync and receive data for one frame at a time
// assumes the bench calls run_frame; the bit clock stands still between frames
`timescale 1ns/1ps
module phpc_hwy_master (
	output logic pcm_clk,
	output logic highway_frame_sync,
	output logic pcm_rx_data,
	input wire logic pcm_tx_data,
	input wire logic pcm_tx_oe
);
	logic oe_q[$];
	logic dat_q[$];
	initial begin
		pcm_clk = 1'b0;
		highway_frame_sync = 1'b0;
		pcm_rx_data = 1'b0;
	end
	// oe and data are taken just before each rise, before the device can react to it
	task automatic run_frame(input int rises, input int rx_start_offset, input int nb, input int ml,
		input logic [15:0] w);
		int k;
		oe_q.delete();
		dat_q.delete();
		highway_frame_sync = 1'b1;
		#40;
		for (k = 0; k <= rises; k++) begin
			oe_q.push_back(pcm_tx_oe);
			dat_q.push_back(pcm_tx_data);
			pcm_clk = 1'b1;
			if (k >= rx_start_offset && k < rx_start_offset + nb * ml) begin
				pcm_rx_data = w[nb - 1 - (k - rx_start_offset) / ml];
			end else begin
				// no pull on the line: toggle so a stale bit cannot pass
				pcm_rx_data = ~pcm_rx_data;
			end
			#80;
			pcm_clk = 1'b0;
			highway_frame_sync = 1'b0;
			#80;
		end
	endtask
endmodule

// >>> pcm_highway_port_control_tb.sv
// self-checking bench: apb registers, tx buffer and serial frames against a queue model
// assumes phpc_top and the highway master model; pcm_clk period 160 ns
`timescale 1ns/1ps
`include "phpc_map.svh"
`define CHK(nm, got, exp) begin \
	checked++; \
	if ((got) !== (exp)) begin \
		err_total++; \
		$display("Error %s expected %0h seen %0h", nm, exp, got); \
	end \
end
module pcm_highway_port_control_tb;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, pcm_clk, highway_frame_sync, pcm_rx_data, pcm_tx_data, pcm_tx_oe;
	logic tx_valid = 1'b0;
	logic [15:0] tx_word = 16'h0;
	logic tx_ready, rx_valid, wideband_active;
	logic [15:0] rx_word;
	logic [1:0] sample_format;
	phpc_pkg::phpc_loop_s loop_mode;
	logic tx_take = 1'b0;
	logic [2:0] pid = `PHPC_PART_ID;
	int err_total = 0;
	int checked = 0;
	int cyc = 0;
	int tx_left = 0;
	int seed = 32'h757a;
	logic [7:0] m [0:8];
	logic [15:0] txq[$];
	logic [15:0] rxq[$];
	phpc_top i_dut (.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .pcm_clk, .highway_frame_sync, .pcm_rx_data, .pcm_tx_data,
		.pcm_tx_oe, .tx_valid, .tx_ready, .tx_word, .rx_valid, .rx_word, .wideband_active,
		.sample_format, .loop_mode);
	phpc_hwy_master i_hwy (.pcm_clk, .highway_frame_sync, .pcm_rx_data, .pcm_tx_data,
		.pcm_tx_oe);
	always #2 clk_sys = ~clk_sys;
	always @(negedge clk_sys) begin
		tx_take = tx_valid === 1'b1 && tx_ready === 1'b1;
		if (rx_valid === 1'b1) rxq.push_back(rx_word);
	end
	// word is held until taken; the model queue records it at the taking edge
	always @(posedge clk_sys) begin
		if (tx_take) begin
			txq.push_back(tx_word);
			tx_left--;
		end
		if (tx_left > 0 && (tx_take || !tx_valid)) begin
			tx_valid <= 1'b1;
			tx_word <= 16'($random(seed));
		end else if (tx_take) begin
			tx_valid <= 1'b0;
		end
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	function automatic logic [7:0] mask_of(input int i);
		case (i)
			1: return 8'h7f;
			2, 4: return 8'hff;
			3, 5: return 8'h03;
			8: return 8'h07;
			default: return 8'h00;
		endcase
	endfunction
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		// answer is taken at the edge that samples pready high, then released
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) err_total++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rreg(input int i);
		logic [31:0] rd;
		logic er;
		apb(1'b0, 8'(i * 4), 32'h0, rd, er);
		`CHK("reg_read", rd, {24'h0, m[i]})
		`CHK("reg_err", er, 1'b0)
	endtask
	task automatic wreg(input int i, input logic [31:0] d);
		logic [31:0] rd;
		logic er;
		apb(1'b1, 8'(i * 4), d, rd, er);
		m[i] = (m[i] & ~mask_of(i)) | (d[7:0] & mask_of(i));
		`CHK("reg_err", er, 1'b0)
	endtask
	task automatic frame(input logic [6:0] md, input int tx_start_offset, input int rx_start_offset, input logic [2:0] lp);
		int nb, ml, endc, e, r, rises;
		logic [15:0] tw, rw, xw;
		nb = md[2] ? 16 : 8;
		ml = md[1] ? 2 : 1;
		rises = (tx_start_offset > rx_start_offset ? tx_start_offset : rx_start_offset) + nb * ml + 4;
		endc = tx_start_offset + nb * ml;
		tw = 16'h0;
		rw = 16'($random(seed));
		wreg(2, 32'(tx_start_offset));
		wreg(3, 32'(tx_start_offset >> 8));
		wreg(4, 32'(rx_start_offset));
		wreg(5, 32'(rx_start_offset >> 8));
		wreg(8, 32'(lp));
		wreg(1, 32'(md));
		if (md[5] && txq.size() > 0) tw = txq.pop_front();
		rxq.delete();
		i_hwy.run_frame(rises, rx_start_offset, nb, ml, rw);
		repeat (100) @(posedge clk_sys);
		for (r = 1; r <= rises; r++) begin
			e = (md[5] && r - 1 >= tx_start_offset && r - 1 < endc - 1) ? 1 : 0;
			if (md[5] && r - 1 == endc - 1) e = md[0] ? 0 : 1;
			`CHK("tx_oe", i_hwy.oe_q[r], e[0])
			if (e == 1) `CHK("tx_bit", i_hwy.dat_q[r], tw[nb - 1 - (r - 1 - tx_start_offset) / ml])
		end
		xw = lp[1] ? tw : rw;
		if (nb == 8) xw[15:8] = 8'h00;
		`CHK("rx_count", rxq.size(), md[5] ? 1 : 0)
		if (md[5]) `CHK("rx_word", rxq[0], xw)
	endtask
	initial begin
		int i;
		logic [31:0] rd;
		logic er;
		logic [7:0] bad [4];
		bad = '{8'h00, 8'h05, 8'h1c, 8'h24};
		for (i = 0; i < 9; i++) m[i] = 8'h00;
		m[1] = {pid[2], 7'h00};
		m[6] = {pid, 5'h00};
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		for (i = 1; i < 9; i++) if (i != 7) rreg(i);
		for (i = 1; i < 9; i++) begin
			if (i != 7) wreg(i, $random(seed));
			if (i != 7) rreg(i);
		end
		foreach (bad[j]) begin
			apb(1'b1, bad[j], 32'hff, rd, er);
			`CHK("slverr", er, 1'b1)
			apb(1'b0, bad[j], 32'h0, rd, er);
			`CHK("bad_read", rd, 32'h0)
			`CHK("bad_err", er, 1'b1)
			rreg(1);
		end
		for (i = 0; i < 8; i++) begin
			wreg(1, 32'h40 | 32'(i << 2));
			// register lands at the access edge, the output flop one edge later
			repeat (2) @(negedge clk_sys);
			`CHK("format", sample_format, i[2:1])
			`CHK("wideband", wideband_active, i[2:1] == 2'b11 && i[0])
		end
		for (i = 0; i < 3; i++) begin
			wreg(8, 32'(1 << i));
			repeat (2) @(negedge clk_sys);
			`CHK("loop", loop_mode, 3'(1 << i))
		end
		tx_left = 3;
		repeat (20) @(posedge clk_sys);
		@(negedge clk_sys);
		`CHK("tx_full", tx_ready, 1'b0)
		`CHK("tx_taken", txq.size() >= 2, 1'b1)
		frame(7'h20, 3, 5, 3'h0);
		frame(7'h0c, 2, 2, 3'h0);
		frame(7'h7f, 10'h102, 10'h105, 3'h0);
		frame(7'h3d, 4, 4, 3'h2);
		complete_run();
	end
endmodule
